// *** src/flyback_cfg.svh ***
// constants for the flyback fault supervisor
`ifndef FLYBACK_CFG_SVH
`define FLYBACK_CFG_SVH
`define CLK_FREQ_KHZ      40000
`define OPP_TIME_MS       85
`define BROWNOUT_TIME_MS  45
`define OVLO_CYCLES       3
`define DIE_HOT_CYCLES    32
`define SHORT_CYCLES      8
`define EXT_OVP_CYCLES    3
`define EXT_OT_CYCLES     32
`define NUM_QUAL          5
`define Q_OVLO            0
`define Q_DIE             1
`define Q_SHORT           2
`define Q_EXT_OVP         3
`define Q_EXT_OT          4
`endif

// *** src/fault_pkg.sv ***
// types shared by the fault supervisor files
package fault_pkg;
	typedef enum logic [2:0] {
		ST_OFF   = 3'h1,
		ST_RUN   = 3'h2,
		ST_FAULT = 3'h4
	} state_t;
endpackage

// *** src/cycle_qualifier.sv ***
// consecutive switching cycle qualifier
module cycle_qualifier #(
	parameter int LIMIT = 3
) (
	input  wire logic core_clk, // clock
	input  wire logic rst,      // sync reset, high
	input  wire logic sample,   // one pulse per switching cycle
	input  wire logic cond,     // condition seen this cycle
	output logic      hit       // qualified level
);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] count;

	initial begin
		if (LIMIT < 1) $error("cycle_qualifier: LIMIT must be at least 1");
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count <= '0;
		end else if (sample) begin
			if (!cond) begin
				count <= '0;
			end else if (count != CW'(LIMIT)) begin
				count <= count + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			hit <= 1'b0;
		end else if (sample) begin
			hit <= cond && (count == CW'(LIMIT - 1) || count == CW'(LIMIT));
		end
	end

	property p_clear_on_absent;
		@(posedge core_clk) disable iff (rst)
		(sample && !cond) |=> (count == '0 && !hit);
	endproperty
	a_clear_on_absent: assert property (p_clear_on_absent)
		else $error("qualifier count not cleared");
endmodule

// *** src/flyback_fault_supervisor.sv ***
// fault supervision for a current-mode flyback controller
`include "flyback_cfg.svh"
module flyback_fault_supervisor #(
	parameter int OPP_CYCLES      = `OPP_TIME_MS * `CLK_FREQ_KHZ,
	parameter int BROWNOUT_CYCLES = `BROWNOUT_TIME_MS * `CLK_FREQ_KHZ
) (
	input  wire logic       core_clk,              // 40 MHz clock
	input  wire logic       rst,                   // sync reset, high
	input  wire logic       cycleStart,            // switching cycle start pulse
	input  wire logic       pwmFall,               // internal PWM falling edge pulse
	input  wire logic       supplyAboveOn,         // supply above turn-on level
	input  wire logic       supplyBelowOff,        // supply at turn-off level
	input  wire logic       supplyAbovePor,        // supply above power-on reset
	input  wire logic       supplyAboveOvlo,       // supply above lockout level
	input  wire logic       dieHot,                // die above hot limit
	input  wire logic       dieCool,               // die below clear limit
	input  wire logic       feedbackAboveRamp,     // feedback above overpower ramp
	input  wire logic       feedbackBelowOpp,      // feedback below overpower level
	input  wire logic       senseAboveLimitBlank,  // sense above limit in blanking
	input  wire logic       faultPinBelowDis,      // fault pin below disable
	input  wire logic       faultPinBelowBrownout, // fault pin below brown-out
	input  wire logic       faultPinAboveOvp,      // fault pin above overvoltage
	input  wire logic       faultPinBelowTsd,      // fault pin below overtemp
	input  wire logic       latchedVariant,        // 1 latched, 0 auto-restart
	input  wire logic       brownoutVariant,       // 1 brown-out, 0 ovp/otp pin
	output logic            gateEnable,            // gate drive allowed
	output logic            faultSink,             // fault current sink on
	output logic            offsetCurrentOn,       // fault pin offset current on
	output logic            latchHold,             // latched fault pending
	output fault_pkg::state_t supplyState          // supervisor state
);
	import fault_pkg::*;

	localparam int OPP_W = $clog2(OPP_CYCLES + 1);
	localparam int BRO_W = $clog2(BROWNOUT_CYCLES + 1);

	initial begin
		if (OPP_CYCLES < 1) $error("OPP_CYCLES must be at least 1");
		if (BROWNOUT_CYCLES < 1) $error("BROWNOUT_CYCLES must be at least 1");
	end

	function automatic int qualLimit(input int idx);
		case (idx)
			`Q_OVLO:    qualLimit = `OVLO_CYCLES;
			`Q_DIE:     qualLimit = `DIE_HOT_CYCLES;
			`Q_SHORT:   qualLimit = `SHORT_CYCLES;
			`Q_EXT_OVP: qualLimit = `EXT_OVP_CYCLES;
			default:    qualLimit = `EXT_OT_CYCLES;
		endcase
	endfunction

	state_t                 next_state;
	logic [`NUM_QUAL-1:0]   qualCond;
	logic [`NUM_QUAL-1:0]   qualHit;
	logic                   qualRst;
	logic [OPP_W-1:0]       oppTimer;
	logic                   oppOver;
	logic                   oppTrip;
	logic [BRO_W-1:0]       brownCount;
	logic                   brownoutFault;
	logic                   brownCond;
	logic                   dieFault;
	logic                   hardFault;
	logic                   next_gate;

	// qualifiers and overpower logic are cleared whenever the supply has dropped out
	assign qualRst = rst || supplyState == ST_OFF;

	// pin meanings depend on the variant; disable masks the overtemp one, not overvoltage
	always_comb begin
		qualCond = '0;
		qualCond[`Q_OVLO]    = supplyAboveOvlo;
		qualCond[`Q_DIE]     = dieHot;
		qualCond[`Q_SHORT]   = senseAboveLimitBlank;
		qualCond[`Q_EXT_OVP] = !brownoutVariant && faultPinAboveOvp;
		qualCond[`Q_EXT_OT]  = !brownoutVariant && faultPinBelowTsd
			&& !faultPinBelowDis;
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_QUAL; g++) begin : gen_qual
			cycle_qualifier #(
				.LIMIT (qualLimit(g))
			) u_qual (
				.core_clk (core_clk),
				.rst      (qualRst),
				.sample   (cycleStart),
				.cond     (qualCond[g]),
				.hit      (qualHit[g])
			);
		end
	endgenerate

	// overpower: over flag refreshed at each PWM fall, timer runs on core clock
	always_ff @(posedge core_clk) begin
		if (qualRst) begin
			oppOver <= 1'b0;
		end else if (pwmFall) begin
			oppOver <= feedbackAboveRamp;
		end
	end

	always_ff @(posedge core_clk) begin
		if (qualRst) begin
			oppTimer <= '0;
		end else if (oppOver && oppTimer != OPP_W'(OPP_CYCLES)) begin
			oppTimer <= oppTimer + 1'b1;
		end else if (!oppOver && feedbackBelowOpp && oppTimer != '0) begin
			// net excess only: short overloads wear off between bursts
			oppTimer <= oppTimer - 1'b1;
		end
	end

	assign oppTrip = oppTimer == OPP_W'(OPP_CYCLES);

	assign hardFault = qualHit[`Q_OVLO] || qualHit[`Q_SHORT] || qualHit[`Q_EXT_OVP]
		|| qualHit[`Q_EXT_OT] || oppTrip;

	// brown-out: time qualified, released the moment the pin recovers
	assign brownCond = brownoutVariant && faultPinBelowBrownout && !faultPinBelowDis;

	always_ff @(posedge core_clk) begin
		if (rst || !brownCond) begin
			brownCount <= '0;
		end else if (brownCount != BRO_W'(BROWNOUT_CYCLES)) begin
			brownCount <= brownCount + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || !brownCond) begin
			brownoutFault <= 1'b0;
		end else if (brownCount == BRO_W'(BROWNOUT_CYCLES - 1)) begin
			brownoutFault <= 1'b1;
		end
	end

	// offset current only once the pin has risen past brown-in
	always_ff @(posedge core_clk) begin
		if (rst || !brownoutVariant || supplyState == ST_OFF) begin
			offsetCurrentOn <= 1'b0;
		end else if (!faultPinBelowBrownout) begin
			offsetCurrentOn <= 1'b1;
		end
	end

	// die overtemperature holds until cooled; the set wins over the clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dieFault <= 1'b0;
		end else if (qualHit[`Q_DIE]) begin
			dieFault <= 1'b1;
		end else if (dieCool) begin
			dieFault <= 1'b0;
		end
	end

	// latched variant: only a supply drop below power-on reset frees it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			latchHold <= 1'b0;
		end else if (latchedVariant && supplyState == ST_RUN
			&& (hardFault || qualHit[`Q_DIE])) begin
			latchHold <= 1'b1;
		end else if (!supplyAbovePor) begin
			latchHold <= 1'b0;
		end
	end

	always_comb begin
		next_state = supplyState;
		case (supplyState)
			ST_OFF: begin
				// each startup retries; a held latch or hot die keeps it off
				if (supplyAboveOn && !latchHold && !dieFault) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (supplyBelowOff) begin
					next_state = ST_OFF;
				end else if (hardFault) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (supplyBelowOff) begin
					next_state = ST_OFF;
				end
			end
			default: next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			supplyState <= ST_OFF;
		end else begin
			supplyState <= next_state;
		end
	end

	// disable and brown-out stop the gate without leaving the run state
	assign next_gate = next_state == ST_RUN && !hardFault && !dieFault && !latchHold
		&& !brownoutFault && !faultPinBelowDis;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			gateEnable <= 1'b0;
		end else begin
			gateEnable <= next_gate;
		end
	end

	// sinking pulls the supply down to turn-off, restarting the cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			faultSink <= 1'b0;
		end else begin
			faultSink <= next_state == ST_FAULT;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_latch_holds;
		(latchHold && supplyState == ST_OFF && supplyAbovePor) |=> supplyState == ST_OFF;
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("latched fault released without power-on reset");

	property p_no_start_low;
		(supplyState == ST_OFF && !supplyAboveOn) |=> (supplyState == ST_OFF && !gateEnable);
	endproperty
	a_no_start_low: assert property (p_no_start_low)
		else $error("started below turn-on level");

	property p_uvlo_stop;
		(supplyState != ST_OFF && supplyBelowOff) |=> (supplyState == ST_OFF && !gateEnable);
	endproperty
	a_uvlo_stop: assert property (p_uvlo_stop)
		else $error("kept running below turn-off level");

	property p_ovlo_trip;
		(supplyState == ST_RUN && qualHit[`Q_OVLO] && !supplyBelowOff)
			|=> (supplyState == ST_FAULT && !gateEnable && faultSink);
	endproperty
	a_ovlo_trip: assert property (p_ovlo_trip)
		else $error("supply overvoltage did not trip");

	property p_short_trip;
		(supplyState == ST_RUN && qualHit[`Q_SHORT] && !supplyBelowOff)
			|=> supplyState == ST_FAULT;
	endproperty
	a_short_trip: assert property (p_short_trip)
		else $error("short circuit did not trip");

	property p_opp_trip;
		(supplyState == ST_RUN && oppTimer == OPP_W'(OPP_CYCLES) && !supplyBelowOff)
			|=> supplyState == ST_FAULT;
	endproperty
	a_opp_trip: assert property (p_opp_trip)
		else $error("overpower timer full did not trip");

	property p_opp_up;
		(pwmFall && feedbackAboveRamp && supplyState != ST_OFF && !supplyBelowOff
			&& oppTimer == '0) |=> ##1 oppTimer == OPP_W'(1);
	endproperty
	a_opp_up: assert property (p_opp_up)
		else $error("overpower timer did not count up");

	property p_disable_now;
		faultPinBelowDis |=> !gateEnable;
	endproperty
	a_disable_now: assert property (p_disable_now)
		else $error("disable did not stop gate at once");

	property p_resume_now;
		($fell(faultPinBelowDis) || $fell(brownoutFault)) && supplyState == ST_RUN
			&& !supplyBelowOff && !hardFault && !dieFault && !latchHold && !brownoutFault
			&& !faultPinBelowDis |=> gateEnable;
	endproperty
	a_resume_now: assert property (p_resume_now)
		else $error("gate not resumed immediately");

	property p_offset_after_brownin;
		$rose(offsetCurrentOn) |-> !$past(faultPinBelowBrownout) && $past(brownoutVariant);
	endproperty
	a_offset_after_brownin: assert property (p_offset_after_brownin)
		else $error("offset current before brown-in");

	property p_die_blocks;
		dieFault |=> !gateEnable;
	endproperty
	a_die_blocks: assert property (p_die_blocks)
		else $error("gate on while die hot");

	// a decrement only while idle, so bursts cost their net excess
	property p_opp_down;
		(supplyState == ST_RUN && !supplyBelowOff && !oppOver && feedbackBelowOpp
			&& oppTimer != '0) |=> oppTimer == $past(oppTimer) - 1'b1;
	endproperty
	a_opp_down: assert property (p_opp_down)
		else $error("overpower timer did not count down");

	property p_pin_ovp_trip;
		(supplyState == ST_RUN && qualHit[`Q_EXT_OVP] && !supplyBelowOff)
			|=> supplyState == ST_FAULT;
	endproperty
	a_pin_ovp_trip: assert property (p_pin_ovp_trip)
		else $error("fault pin overvoltage did not trip");

	// the fault may only appear once the whole qualification time is spent
	property p_brown_full;
		$rose(brownoutFault) |-> brownCount == BRO_W'(BROWNOUT_CYCLES);
	endproperty
	a_brown_full: assert property (p_brown_full)
		else $error("brown-out tripped before full time");

	property p_brown_gate;
		brownoutFault |=> !gateEnable;
	endproperty
	a_brown_gate: assert property (p_brown_gate)
		else $error("gate on during brown-out");

	c_fault_cycle: cover property (supplyState == ST_FAULT ##1 supplyState == ST_OFF);
	c_brownout:    cover property ($rose(brownoutFault));
	c_latched:     cover property ($rose(latchHold));
	c_restart:     cover property (supplyState == ST_OFF ##1 supplyState == ST_RUN);
endmodule

// *** sim/comparator_model.sv ***
// analog front end model: comparators and switching cycle timing
module comparator_model (
	input  wire logic core_clk,              // clock
	input  int        vddMv,                 // supply level
	input  int        pinMv,                 // fault pin level
	input  int        senseMv,               // sense peak in blanking
	input  int        dieC,                  // die temperature
	input  wire logic fbOver,                // feedback overloaded
	output logic      cycleStart,            // cycle start pulse
	output logic      pwmFall,               // pwm falling edge pulse
	output logic      supplyAboveOn,         // turn-on comparator
	output logic      supplyBelowOff,        // turn-off comparator
	output logic      supplyAbovePor,        // power-on reset comparator
	output logic      supplyAboveOvlo,       // lockout comparator
	output logic      dieHot,                // hot limit
	output logic      dieCool,               // clear limit
	output logic      feedbackAboveRamp,     // feedback above ramp
	output logic      feedbackBelowOpp,      // feedback below threshold
	output logic      senseAboveLimitBlank,  // short pulse seen
	output logic      faultPinBelowDis,      // disable comparator
	output logic      faultPinBelowBrownout, // brown-out comparator
	output logic      faultPinAboveOvp,      // overvoltage comparator
	output logic      faultPinBelowTsd       // overtemp comparator
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] phase = 2'h0;
	// four clocks per cycle keeps long qualifications short
	always @(posedge core_clk) begin
		#2;
		phase = phase + 2'h1;
	end
	assign cycleStart = (phase == 2'h0);
	assign pwmFall = (phase == 2'h2);
	assign supplyAboveOn = (vddMv > 15300);
	assign supplyBelowOff = (vddMv <= 9000);
	assign supplyAbovePor = (vddMv > 5000);
	assign supplyAboveOvlo = (vddMv > 28000);
	assign dieHot = (dieC >= 160);
	assign dieCool = (dieC < 140);
	assign feedbackAboveRamp = fbOver;
	assign feedbackBelowOpp = !fbOver;
	assign senseAboveLimitBlank = (senseMv > 900);
	assign faultPinBelowDis = (pinMv < 500);
	assign faultPinBelowBrownout = (pinMv < 1400);
	assign faultPinAboveOvp = (pinMv > 4000);
	assign faultPinBelowTsd = (pinMv < 1000);
endmodule

// *** sim/flyback_fault_supervisor_bench.sv ***
// self-checking bench for the flyback fault supervisor
module flyback_fault_supervisor_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import fault_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic fbOver = 1'b0;
	logic latched = 1'b0;
	logic brown = 1'b0;
	int vddMv = 12000;
	int pinMv = 2000;
	int senseMv = 0;
	int dieC = 25;
	int fail_count = 0;
	int checks = 0;
	logic cs, pf, aOn, bOff, aPor, aOv, hot, cool, aRamp, bOpp, sense, pDis, pBo, pOvp, pTsd;
	logic gate, sink, offs, hold;
	state_t st;
	comparator_model u_comparator_model (.core_clk(core_clk), .vddMv(vddMv), .pinMv(pinMv),
		.senseMv(senseMv), .dieC(dieC), .fbOver(fbOver), .cycleStart(cs), .pwmFall(pf),
		.supplyAboveOn(aOn), .supplyBelowOff(bOff), .supplyAbovePor(aPor),
		.supplyAboveOvlo(aOv), .dieHot(hot), .dieCool(cool), .feedbackAboveRamp(aRamp),
		.feedbackBelowOpp(bOpp), .senseAboveLimitBlank(sense), .faultPinBelowDis(pDis),
		.faultPinBelowBrownout(pBo), .faultPinAboveOvp(pOvp), .faultPinBelowTsd(pTsd));
	flyback_fault_supervisor #(.OPP_CYCLES(20), .BROWNOUT_CYCLES(10))
	u_flyback_fault_supervisor (.core_clk(core_clk), .rst(rst), .cycleStart(cs),
		.pwmFall(pf), .supplyAboveOn(aOn), .supplyBelowOff(bOff), .supplyAbovePor(aPor),
		.supplyAboveOvlo(aOv), .dieHot(hot), .dieCool(cool), .feedbackAboveRamp(aRamp),
		.feedbackBelowOpp(bOpp), .senseAboveLimitBlank(sense), .faultPinBelowDis(pDis),
		.faultPinBelowBrownout(pBo), .faultPinAboveOvp(pOvp), .faultPinBelowTsd(pTsd),
		.latchedVariant(latched), .brownoutVariant(brown), .gateEnable(gate),
		.faultSink(sink), .offsetCurrentOn(offs), .latchHold(hold), .supplyState(st));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic got, input logic exp, input string msg);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic chkSt(input state_t exp, input string msg);
		checks++;
		if (st !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s state %b", $time, msg, st);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	// wait n switching cycles, ending just after the sampling edge
	task automatic ncyc(input int n);
		repeat (n) begin
			do @(posedge core_clk); while (cs !== 1'b1);
		end
		#2;
	endtask
	task automatic restart();
		vddMv = 8000;
		cyc(2);
		vddMv = 16000;
		cyc(2);
	endtask
	task automatic t_start();
		vddMv = 16000;
		cyc(2);
		chkSt(ST_RUN, "start");
		chk(gate, 1'b1, "gate on start");
	endtask
	task automatic t_ovlo();
		vddMv = 29000;
		ncyc(2);
		cyc(2);
		chk(gate, 1'b1, "ovlo early");
		ncyc(1);
		cyc(2);
		chkSt(ST_FAULT, "ovlo");
		chk(sink, 1'b1, "sink");
		vddMv = 16000;
		cyc(3);
		chk(gate, 1'b0, "fault holds gate");
		vddMv = 8000;
		cyc(2);
		chkSt(ST_OFF, "turn-off");
		vddMv = 16000;
		cyc(2);
		chkSt(ST_RUN, "auto restart");
		vddMv = 29000;
		ncyc(3);
		cyc(2);
		chkSt(ST_FAULT, "fault again");
		restart();
	endtask
	task automatic t_disable();
		pinMv = 300;
		cyc(2);
		chk(gate, 1'b0, "disable");
		pinMv = 2000;
		cyc(2);
		chk(gate, 1'b1, "enable");
	endtask
	task automatic t_short();
		senseMv = 950;
		ncyc(7);
		senseMv = 0;
		ncyc(1);
		senseMv = 950;
		ncyc(7);
		cyc(2);
		chk(gate, 1'b1, "short count cleared");
		ncyc(1);
		cyc(2);
		chkSt(ST_FAULT, "short");
		senseMv = 0;
		restart();
	endtask
	task automatic t_die();
		dieC = 165;
		ncyc(31);
		cyc(2);
		chk(gate, 1'b1, "die early");
		ncyc(1);
		cyc(2);
		chk(gate, 1'b0, "die hot");
		dieC = 150;
		cyc(3);
		chk(gate, 1'b0, "hysteresis");
		dieC = 130;
		cyc(3);
		chk(gate, 1'b1, "die cool");
	endtask
	task automatic t_opp();
		fbOver = 1'b1;
		cyc(12);
		fbOver = 1'b0;
		cyc(12);
		fbOver = 1'b1;
		cyc(12);
		chk(gate, 1'b1, "opp net count");
		cyc(16);
		chkSt(ST_FAULT, "opp");
		fbOver = 1'b0;
		restart();
	endtask
	task automatic t_latched();
		vddMv = 8000;
		latched = 1'b1;
		cyc(2);
		vddMv = 16000;
		cyc(2);
		vddMv = 29000;
		ncyc(3);
		cyc(2);
		chk(hold, 1'b1, "latch set");
		restart();
		chk(gate, 1'b0, "latch blocks");
		vddMv = 3000;
		cyc(2);
		chk(hold, 1'b0, "por clears");
		vddMv = 16000;
		cyc(2);
		chkSt(ST_RUN, "latch released");
		latched = 1'b0;
	endtask
	task automatic t_ext();
		pinMv = 4500;
		ncyc(3);
		cyc(2);
		chkSt(ST_FAULT, "pin ovp");
		pinMv = 2000;
		restart();
		pinMv = 800;
		ncyc(32);
		cyc(2);
		chk(gate, 1'b0, "pin overtemp");
		vddMv = 8000;
		brown = 1'b1;
		pinMv = 1200;
		cyc(2);
		vddMv = 16000;
		cyc(3);
		chk(offs, 1'b0, "no offset before brown-in");
	endtask
	task automatic t_brown();
		pinMv = 2000;
		cyc(3);
		chk(offs, 1'b1, "offset on");
		pinMv = 1200;
		cyc(8);
		chk(gate, 1'b1, "brown early");
		cyc(4);
		chk(gate, 1'b0, "brown-out");
		pinMv = 2000;
		cyc(3);
		chk(gate, 1'b1, "brown recover");
	endtask
	task automatic wrap_up();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial begin
		cyc(4);
		chk(gate, 1'b0, "reset gate");
		chkSt(ST_OFF, "reset state");
		rst = 1'b0;
		cyc(3);
		chk(gate, 1'b0, "below turn-on");
		t_start();
		t_ovlo();
		t_disable();
		t_short();
		t_die();
		t_opp();
		t_latched();
		t_ext();
		t_brown();
		wrap_up();
	end
endmodule
